// ===== rtl/pulse_io_regs.svh
/*
  Register offsets, field limits, reset values and timing counts of the pulse I/O and archive block.
  Assumes a byte-addressed 32-bit register port with word-aligned offsets.
*/
`ifndef PULSE_IO_REGS_SVH
`define PULSE_IO_REGS_SVH
`define A_IN_MODE      8'h00
`define A_METER        8'h04
`define A_BIN_CFG      8'h08
`define A_OUT_CFG      8'h0C
`define A_OUT_CMD      8'h10
`define A_OUT_TIME     8'h14
`define A_PERIOD       8'h18
`define A_CALENDAR     8'h1C
`define A_EPOCH        8'h20
`define A_CMD          8'h24
`define A_STATUS       8'h28
`define A_DAYTIME      8'h2C
`define A_COUNT_HI     4'h3
`define A_BACKUP_HI    4'h4
`define A_BASE_VOL     8'h50
`define A_ERR_VOL      8'h54
`define A_MIN          8'h58
`define A_MAX          8'h5C
`define A_MIN_TIME     8'h60
`define A_MAX_TIME     8'h64
`define A_SET_USED     8'h68
`define CNT_MAX        30'h3B9AC9FF
`define CNT_MOD        31'h3B9ACA00
`define EXP_LO         (-3'sh2)
`define EXP_HI         3'sh2
`define PERIOD_MIN_S   12'h001
`define PERIOD_MAX_S   12'hE10
`define PERIOD_RST     12'hE10
`define SEC_PER_DAY    17'h15180
`define SEC_PER_HOUR   17'h00E10
`define HOURS_PER_DAY  5'h18
`define GAS_HOUR_RST   5'h06
`define DIM_MIN        5'h1C
`define DIM_MAX        5'h1F
`define BIN_LEVEL_RST  8'hFF
`define DAILY_DEPTH    12'h064
`define MONTHLY_DEPTH  12'h019
`define EVENT_DEPTH    12'h7D0
`define PER_DEPTH_RST  12'h800
`define SET_CAP        15'h4000
`define SET_REC_METER  15'h0010
`define PULSE_MAX      16'hFFFF
`define RETRY_S        12'hE10
`define MS_PER_S       10'h3E8
`define CLK_HZ         200000000
`define TICK_MS        1
`endif

// ===== rtl/pulse_io_pkg.sv
/*
  Types and reset state of the pulse I/O and archive block.
  Assumes the register header is on the include path.
*/
package pulse_io_pkg;
  `include "pulse_io_regs.svh"

  typedef enum logic [1:0] {IN_LF = 2'h0, IN_HF = 2'h1, IN_BIN = 2'h2} in_mode_t;
  typedef enum logic [2:0] {REC_PERIODIC = 3'h0, REC_DAILY = 3'h1, REC_MONTHLY = 3'h2,
                            REC_EVENT = 3'h3, REC_SETTING = 3'h4} rec_kind_t;
  typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_HIGH = 2'h1, PH_LOW = 2'h3} ph_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } tick_st_t;

  typedef struct packed {
    ph_t         ph;
    logic [15:0] timer;
    logic [15:0] debt;
    logic        pin;
  } pulse_st_t;

  typedef struct packed {
    logic [10:0]       sync1;
    logic [10:0]       sync2;
    logic [7:0]        prev_in;
    logic              batt_prev;
    logic [3:0][1:0]   in_mode;
    logic [11:0]       meter;
    logic [7:0]        bin_level;
    logic [7:0]        log_en;
    logic [3:0]        pulse_mode;
    logic [3:0]        master_src;
    logic [3:0]        master_lvl;
    logic [15:0]       width;
    logic [15:0]       period;
    logic [11:0]       arch_per;
    logic [4:0]        gas_hour;
    logic [4:0]        dim;
    logic [31:0]       epoch;
    logic [16:0]       sod;
    logic [4:0]        dom;
    logic [9:0]        ms_cnt;
    logic [3:0][29:0]  cnt;
    logic [3:0][29:0]  backup;
    logic [3:0][29:0]  pend;
    logic [29:0]       base_vol;
    logic [29:0]       err_vol;
    logic [15:0]       mn;
    logic [15:0]       mx;
    logic [31:0]       mn_t;
    logic [31:0]       mx_t;
    logic              ext_valid;
    logic [14:0]       set_used;
    logic              set_full;
    logic              rej;
    logic [11:0]       per_cnt;
    logic [15:0]       sticky;
    logic [15:0]       snap_per;
    logic [15:0]       prev_evt;
    logic [15:0]       evt_bits;
    logic [11:0]       ptr_per;
    logic [11:0]       ptr_day;
    logic [11:0]       ptr_mon;
    logic [11:0]       ptr_evt;
    logic [4:0]        pend_rec;
    logic [14:0]       set_idx;
    logic [1:0]        supply_en;
    logic [1:0][11:0]  retry;
    logic              rec_stb;
    logic [2:0]        rec_kind;
    logic [14:0]       rec_index;
    logic [31:0]       rec_time;
    logic [15:0]       rec_bits;
    logic [31:0]       rdata;
  } st_t;

  localparam st_t ST_RST = '{arch_per: `PERIOD_RST, gas_hour: `GAS_HOUR_RST, dim: `DIM_MAX, dom: 5'h01,
                             bin_level: `BIN_LEVEL_RST, supply_en: 2'h3, default: '0};
endpackage

// ===== rtl/tick_divider.sv
/*
  Divider that makes a one-cycle enable pulse every CYCLES clocks.
  Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module tick_divider import pulse_io_pkg::*; #(
  parameter int CYCLES = 200000
) (
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      tick
);
  tick_st_t s;
  tick_st_t n;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (s.cnt >= 32'(CYCLES - 1)) begin
      n.cnt = 32'h0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule

// ===== rtl/pulse_out_unit.sv
/*
  One output channel: static level or pulse train paid out of a saturating pulse debt.
  Assumes a one-cycle millisecond enable and same-clock request inputs.
*/
`timescale 1ns/100ps
module pulse_out_unit import pulse_io_pkg::*; (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ms_tick,
  input  wire logic        pulse_mode,
  input  wire logic [15:0] width_ms,
  input  wire logic [15:0] period_ms,
  input  wire logic        level,
  input  wire logic        add_stb,
  input  wire logic [15:0] add_cnt,
  output logic             pin
);
  pulse_st_t   s;
  pulse_st_t   n;
  logic [16:0] sum;
  logic [15:0] d;
  logic [15:0] t1;

  always_comb begin
    n = s;
    sum = {1'b0, s.debt} + {1'b0, add_cnt};
    d = s.debt;
    t1 = s.timer + 16'h0001;
    if (add_stb) begin
      d = sum[16] ? `PULSE_MAX : sum[15:0];
    end
    n.debt = d;
    if (!pulse_mode) begin
      n.pin = level;
      n.ph = PH_IDLE;
      n.debt = 16'h0000;
    end else begin
      unique case (s.ph)
        PH_IDLE: begin
          n.pin = 1'b0;
          if (d != 16'h0000) begin
            n.ph = PH_HIGH;
            n.pin = 1'b1;
            n.timer = 16'h0000;
            n.debt = d - 16'h0001;
          end
        end
        PH_HIGH: begin
          if (ms_tick) begin
            n.timer = t1;
            if (t1 >= width_ms) begin
              n.ph = PH_LOW;
              n.pin = 1'b0;
            end
          end
        end
        PH_LOW: begin
          if (ms_tick) begin
            n.timer = t1;
            if (t1 >= period_ms) begin
              n.ph = PH_IDLE;
            end
          end
        end
        default: begin
          n.ph = PH_IDLE;
          n.pin = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign pin = s.pin;
endmodule

// ===== rtl/pulse_io_event_archiver.sv
/*
  Pulse and binary input counting, output drive, time base, archive record scheduling, extremes,
  setting archive accounting and supply overload handling. Assumes a plain register port, pins
  from outside the clock domain, and status inputs from logic on the same clock.
*/
// Strobed register access and the address map were left to the implementer.
// How it works
// - Eight digital inputs in two groups of four.
// - First four inputs pick LF, HF or binary; other four are binary only.
// - LF pulses counted while battery is off are added into backup counters on reconnect.
// - LF counters hold nine digits; meter constant scales the displayed value.
// - HF counters also hold nine digits.
// - Meter constant must be a power of ten from 0.01 to 100, else refused.
// - Each binary input has an active level and an event logging enable.
// - Four outputs, each static level or pulse train with set width and period.
// - Each output follows internal logic or the master, never both.
// - Pending output pulses saturate at 65535.
// - Base and error volume counters hold nine integer digits each.
// - Periodic record every 1 s to 1 hour, with timestamp.
// - Periodic archive index wraps so the oldest record is replaced.
// - Periodic bits record any active state seen during the interval.
// - Setpoint and error bits are active high; binary inputs use their level.
// - Daily record at the gas-day hour, 100 record ring.
// - Monthly record at gas-day hour on day one, 25 record ring.
// - Event record on any change of setpoint, error or log-enabled binary bits, 1 s stamp, 2000 record ring.
// - Extreme init loads present value into both minimum and maximum.
// - Setting archive never wraps; at 16 KB it refuses records and the change.
// - Each extreme carries the time it occurred.
// - Overloaded supply circuit is cut and retried once per hour.
`timescale 1ns/100ps
`include "pulse_io_regs.svh"
module pulse_io_event_archiver import pulse_io_pkg::*; #(
  parameter int          MS_CYCLES = `CLK_HZ / 1000 * `TICK_MS,
  parameter logic [11:0] PER_DEPTH = `PER_DEPTH_RST
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  input  wire logic [7:0]  pin_in,
  input  wire logic        battery_ok,
  input  wire logic [1:0]  overload,
  input  wire logic [3:0]  setpoint,
  input  wire logic [3:0]  error_bits,
  input  wire logic [3:0]  alarm_req,
  input  wire logic [3:0]  volume_pulse,
  input  wire logic        vol_stb,
  input  wire logic        err_cond,
  input  wire logic [15:0] meas_val,
  input  wire logic        meas_stb,
  output logic      [3:0]  out_pin,
  output logic      [1:0]  supply_en,
  output logic             rec_stb,
  output logic      [2:0]  rec_kind,
  output logic      [14:0] rec_index,
  output logic      [31:0] rec_time,
  output logic      [15:0] rec_bits
);
  st_t              s;
  st_t              n;
  logic             ms_tick;
  logic             sec;
  logic             batt;
  logic             ok;
  logic             found;
  logic             meter_wr;
  logic             set_req;
  logic [14:0]      set_len;
  logic [2:0]       sel;
  logic [16:0]      sod_n;
  logic [16:0]      gas_sec;
  logic [7:0]       rise;
  logic [7:0]       bin_act;
  logic [15:0]      mon;
  logic [15:0]      evt;
  logic [3:0]       lvl;
  logic [3:0]       add_stb;
  logic [3:0][15:0] add_cnt;

  function automatic logic [29:0] wrap_add(input logic [29:0] a, input logic [29:0] b);
    logic [30:0] t;
    t = {1'b0, a} + {1'b0, b};
    if (t > {1'b0, `CNT_MAX}) begin
      t = t - `CNT_MOD;
    end
    return t[29:0];
  endfunction

  function automatic logic [11:0] ptr_next(input logic [11:0] p, input logic [11:0] depth);
    return (p >= depth - 12'h001) ? 12'h000 : p + 12'h001;
  endfunction

  function automatic logic exp_ok(input logic [2:0] e);
    return ($signed(e) >= `EXP_LO) && ($signed(e) <= `EXP_HI);
  endfunction

  function automatic logic set_fits(input logic [14:0] used, input logic [14:0] len);
    return ({1'b0, used} + {1'b0, len}) <= {1'b0, `SET_CAP};
  endfunction

  tick_divider #(.CYCLES(MS_CYCLES)) u_ms (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (ms_tick)
  );

  for (genvar i = 0; i < 4; i++) begin : g_out
    pulse_out_unit u_out (
      .clk        (clk),
      .reset_n    (reset_n),
      .ms_tick    (ms_tick),
      .pulse_mode (s.pulse_mode[i]),
      .width_ms   (s.width),
      .period_ms  (s.period),
      .level      (lvl[i]),
      .add_stb    (add_stb[i]),
      .add_cnt    (add_cnt[i]),
      .pin        (out_pin[i])
    );
  end

  always_comb begin
    n = s;
    n.rec_stb = 1'b0;
    n.rdata = 32'h0;
    ok = 1'b1;
    meter_wr = 1'b0;
    set_req = 1'b0;
    set_len = `SET_REC_METER;
    sec = 1'b0;
    gas_sec = s.gas_hour * `SEC_PER_HOUR;
    n.sync1 = {overload, battery_ok, pin_in};
    n.sync2 = s.sync1;
    batt = s.sync2[8];
    rise = s.sync2[7:0] & ~s.prev_in;
    n.prev_in = s.sync2[7:0];
    n.batt_prev = batt;

    // Record issue; later sets of a pending bit in this cycle win over the clear
    sel = 3'h0;
    found = 1'b0;
    for (int k = 4; k >= 0; k--) begin
      if (s.pend_rec[k]) begin
        sel = 3'(k);
        found = 1'b1;
      end
    end
    if (found) begin
      n.pend_rec[sel] = 1'b0;
      n.rec_stb = 1'b1;
      n.rec_kind = sel;
      n.rec_time = s.epoch;
      n.rec_bits = 16'h0000;
      unique case (rec_kind_t'(sel))
        REC_PERIODIC: begin
          n.rec_index = {3'h0, s.ptr_per};
          n.ptr_per = ptr_next(s.ptr_per, PER_DEPTH);
          n.rec_bits = s.snap_per;
        end
        REC_DAILY: begin
          n.rec_index = {3'h0, s.ptr_day};
          n.ptr_day = ptr_next(s.ptr_day, `DAILY_DEPTH);
        end
        REC_MONTHLY: begin
          n.rec_index = {3'h0, s.ptr_mon};
          n.ptr_mon = ptr_next(s.ptr_mon, `MONTHLY_DEPTH);
        end
        REC_EVENT: begin
          n.rec_index = {3'h0, s.ptr_evt};
          n.ptr_evt = ptr_next(s.ptr_evt, `EVENT_DEPTH);
          n.rec_bits = s.evt_bits;
        end
        REC_SETTING: begin
          n.rec_index = s.set_idx;
        end
      endcase
    end

    // Input classification and counting
    for (int i = 0; i < 8; i++) begin
      bin_act[i] = (s.sync2[i] == s.bin_level[i]) && ((i >= 4) || (s.in_mode[i % 4] == IN_BIN));
    end
    mon = {error_bits, setpoint, bin_act};
    evt = {error_bits, setpoint, bin_act & s.log_en};
    for (int i = 0; i < 4; i++) begin
      if (batt && !s.batt_prev) begin
        n.backup[i] = wrap_add(s.backup[i], s.pend[i]);
        n.pend[i] = 30'h0;
      end
      if (rise[i] && (s.in_mode[i] != IN_BIN)) begin
        n.cnt[i] = wrap_add(s.cnt[i], 30'h1);
        if (s.in_mode[i] == IN_LF) begin
          if (batt) begin
            n.backup[i] = wrap_add(n.backup[i], 30'h1);
          end else begin
            n.pend[i] = wrap_add(s.pend[i], 30'h1);
          end
        end
      end
    end
    if (vol_stb) begin
      if (err_cond) begin
        n.err_vol = wrap_add(s.err_vol, 30'h1);
      end else begin
        n.base_vol = wrap_add(s.base_vol, 30'h1);
      end
    end

    // Output source selection
    for (int i = 0; i < 4; i++) begin
      lvl[i] = s.master_src[i] ? s.master_lvl[i] : alarm_req[i];
      add_stb[i] = s.master_src[i] ? (wr_stb && (addr == `A_OUT_CMD) && wdata[4 + i]) : volume_pulse[i];
      add_cnt[i] = s.master_src[i] ? wdata[31:16] : 16'h0001;
    end

    // Time base, daily and monthly points
    if (ms_tick) begin
      sec = (s.ms_cnt >= `MS_PER_S - 10'h001);
      n.ms_cnt = sec ? 10'h000 : s.ms_cnt + 10'h001;
    end
    sod_n = (s.sod >= `SEC_PER_DAY - 17'h00001) ? 17'h00000 : s.sod + 17'h00001;
    if (sec) begin
      n.epoch = s.epoch + 32'h1;
      n.sod = sod_n;
      if (sod_n == 17'h00000) begin
        n.dom = (s.dom >= s.dim) ? 5'h01 : s.dom + 5'h01;
      end
      if (sod_n == gas_sec) begin
        n.pend_rec[REC_DAILY] = 1'b1;
        if (n.dom == 5'h01) begin
          n.pend_rec[REC_MONTHLY] = 1'b1;
        end
      end
    end

    // Periodic interval with sticky bits
    n.sticky = s.sticky | mon;
    if (sec) begin
      if (s.per_cnt >= s.arch_per - 12'h001) begin
        n.per_cnt = 12'h000;
        n.snap_per = s.sticky | mon;
        n.sticky = mon;
        n.pend_rec[REC_PERIODIC] = 1'b1;
      end else begin
        n.per_cnt = s.per_cnt + 12'h001;
      end
    end

    // Event archive trigger
    n.prev_evt = evt;
    if (evt != s.prev_evt) begin
      n.evt_bits = evt;
      n.pend_rec[REC_EVENT] = 1'b1;
    end

    // Extremes
    if (wr_stb && (addr == `A_CMD) && wdata[0]) begin
      n.mn = meas_val;
      n.mx = meas_val;
      n.mn_t = s.epoch;
      n.mx_t = s.epoch;
      n.ext_valid = 1'b1;
    end else if (meas_stb && s.ext_valid) begin
      if (meas_val < s.mn) begin
        n.mn = meas_val;
        n.mn_t = s.epoch;
      end
      if (meas_val > s.mx) begin
        n.mx = meas_val;
        n.mx_t = s.epoch;
      end
    end

    // Supply overload cut-off and hourly retry
    for (int k = 0; k < 2; k++) begin
      if (s.supply_en[k] && s.sync2[9 + k]) begin
        n.supply_en[k] = 1'b0;
        n.retry[k] = 12'h000;
      end else if (!s.supply_en[k] && sec) begin
        if (s.retry[k] >= `RETRY_S - 12'h001) begin
          n.supply_en[k] = 1'b1;
          n.retry[k] = 12'h000;
        end else begin
          n.retry[k] = s.retry[k] + 12'h001;
        end
      end
    end

    // Register writes
    if (wr_stb) begin
      unique case (addr)
        `A_IN_MODE: begin
          for (int i = 0; i < 4; i++) begin
            if (wdata[2 * i +: 2] == 2'h3) begin
              ok = 1'b0;
            end
          end
          if (ok) begin
            n.in_mode = wdata[7:0];
          end
        end
        `A_METER: begin
          for (int i = 0; i < 4; i++) begin
            if (!exp_ok(wdata[3 * i +: 3])) begin
              ok = 1'b0;
            end
          end
          meter_wr = 1'b1;
          set_req = ok;
        end
        `A_BIN_CFG: begin
          n.bin_level = wdata[7:0];
          n.log_en = wdata[15:8];
        end
        `A_OUT_CFG: begin
          n.pulse_mode = wdata[3:0];
          n.master_src = wdata[7:4];
        end
        `A_OUT_CMD: begin
          n.master_lvl = wdata[3:0];
        end
        `A_OUT_TIME: begin
          n.width = wdata[15:0];
          n.period = wdata[31:16];
        end
        `A_PERIOD: begin
          ok = (wdata[11:0] >= `PERIOD_MIN_S) && (wdata[11:0] <= `PERIOD_MAX_S) && (wdata[31:12] == 20'h0);
          if (ok) begin
            n.arch_per = wdata[11:0];
            n.per_cnt = 12'h000;
          end
        end
        `A_CALENDAR: begin
          ok = (wdata[4:0] < `HOURS_PER_DAY) && (wdata[12:8] >= `DIM_MIN) && (wdata[12:8] <= `DIM_MAX);
          if (ok) begin
            n.gas_hour = wdata[4:0];
            n.dim = wdata[12:8];
          end
        end
        `A_EPOCH: begin
          n.epoch = wdata;
        end
        `A_DAYTIME: begin
          ok = (wdata[16:0] < `SEC_PER_DAY) && (wdata[28:24] != 5'h00) && (wdata[28:24] <= s.dim);
          if (ok) begin
            n.sod = wdata[16:0];
            n.dom = wdata[28:24];
          end
        end
        `A_CMD: begin
          if (wdata[1]) begin
            n.set_used = 15'h0000;
            n.set_full = 1'b0;
          end else if (wdata[2]) begin
            set_req = 1'b1;
            set_len = wdata[30:16];
          end
        end
        default: begin
        end
      endcase
      if (set_req) begin
        if (set_fits(s.set_used, set_len)) begin
          n.set_idx = s.set_used;
          n.set_used = s.set_used + set_len;
          n.pend_rec[REC_SETTING] = 1'b1;
        end else begin
          ok = 1'b0;
          n.set_full = 1'b1;
        end
      end
      if (meter_wr && ok) begin
        n.meter = wdata[11:0];
      end
      n.rej = !ok;
    end

    // Register reads
    if (rd_stb) begin
      unique case (addr)
        `A_IN_MODE:  n.rdata = {24'h0, s.in_mode};
        `A_METER:    n.rdata = {20'h0, s.meter};
        `A_BIN_CFG:  n.rdata = {16'h0, s.log_en, s.bin_level};
        `A_OUT_CFG:  n.rdata = {24'h0, s.master_src, s.pulse_mode};
        `A_OUT_CMD:  n.rdata = {28'h0, s.master_lvl};
        `A_OUT_TIME: n.rdata = {s.period, s.width};
        `A_PERIOD:   n.rdata = {20'h0, s.arch_per};
        `A_CALENDAR: n.rdata = {19'h0, s.dim, 3'h0, s.gas_hour};
        `A_EPOCH:    n.rdata = s.epoch;
        `A_STATUS:   n.rdata = {mon, 11'h0, s.rej, s.supply_en, batt, s.set_full};
        `A_DAYTIME:  n.rdata = {3'h0, s.dom, 7'h0, s.sod};
        `A_BASE_VOL: n.rdata = {2'h0, s.base_vol};
        `A_ERR_VOL:  n.rdata = {2'h0, s.err_vol};
        `A_MIN:      n.rdata = {16'h0, s.mn};
        `A_MAX:      n.rdata = {16'h0, s.mx};
        `A_MIN_TIME: n.rdata = s.mn_t;
        `A_MAX_TIME: n.rdata = s.mx_t;
        `A_SET_USED: n.rdata = {17'h0, s.set_used};
        default: begin
          if (addr[7:4] == `A_COUNT_HI) begin
            n.rdata = {2'h0, s.cnt[addr[3:2]]};
          end else if (addr[7:4] == `A_BACKUP_HI) begin
            n.rdata = {2'h0, s.backup[addr[3:2]]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign supply_en = s.supply_en;
  assign rec_stb = s.rec_stb;
  assign rec_kind = s.rec_kind;
  assign rec_index = s.rec_index;
  assign rec_time = s.rec_time;
  assign rec_bits = s.rec_bits;
endmodule

// ===== tb/pulse_io_checker.sv
/* Port assertions of the archiver.
   Assumes a bind into every archiver instance. */
`timescale 1ns/100ps
module pulse_io_checker #(
  parameter logic [11:0] PER_DEPTH = 12'h800
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        rd_stb,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  overload,
  input wire logic [1:0]  supply_en,
  input wire logic        rec_stb,
  input wire logic [2:0]  rec_kind,
  input wire logic [14:0] rec_index
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("read data outside slot");
  a_supply_cut: assert property ((supply_en[0] && overload[0]) [*3] |=> !supply_en[0])
    else $error("overload not cut");
  a_kind_known: assert property (rec_stb |-> rec_kind <= 3'h4)
    else $error("bad record kind");
  a_per_ring: assert property (rec_stb && rec_kind == 3'h0 |-> rec_index < 15'(PER_DEPTH))
    else $error("periodic slot");
  a_day_ring: assert property (rec_stb && rec_kind == 3'h1 |-> rec_index < 15'h064)
    else $error("daily slot");
  a_month_ring: assert property (rec_stb && rec_kind == 3'h2 |-> rec_index < 15'h019)
    else $error("monthly slot");
  a_event_ring: assert property (rec_stb && rec_kind == 3'h3 |-> rec_index < 15'h7D0)
    else $error("event slot");
  a_set_room: assert property (rec_stb && rec_kind == 3'h4 |-> rec_index < 15'h4000)
    else $error("setting offset");
endmodule
bind pulse_io_event_archiver pulse_io_checker #(.PER_DEPTH(PER_DEPTH)) chk (.clk(clk), .reset_n(reset_n),
  .rd_stb(rd_stb), .rdata(rdata), .overload(overload), .supply_en(supply_en), .rec_stb(rec_stb),
  .rec_kind(rec_kind), .rec_index(rec_index));

// ===== tb/pulse_source.sv
/* Pulse transmitters and binary sources.
   Assumes the bench calls burst just after a clock edge. */
`timescale 1ns/100ps
module pulse_source (
  input  wire logic       clk,
  output logic      [7:0] pins
);
  initial pins = 8'h00;
  task burst(input int ch, input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      pins[ch] <= 1'b1;
      repeat (3) @(posedge clk);
      pins[ch] <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

// ===== tb/pulse_io_event_archiver_tb_top.sv
/* Bench of the archiver.
   Assumes a 10-cycle ms tick and a 4-slot ring. */
`timescale 1ns/100ps
`include "pulse_io_regs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("FAIL %s exp %0h got %0h", n, e, g); end end
module pulse_io_event_archiver_tb_top;
  logic        clk, reset_n, wr_stb, rd_stb, battery_ok, vol_stb, err_cond, meas_stb, rec_stb;
  logic [7:0]  addr, pin_in;
  logic [31:0] wdata, rdata, d, rt;
  logic [1:0]  overload, supply_en;
  logic [3:0]  setpoint, error_bits, alarm_req, volume_pulse, out_pin;
  logic [15:0] meas_val, rec_bits;
  logic [2:0]  rec_kind;
  logic [14:0] rec_index, prv;
  int          n_errors = 0, checked = 0, cyc = 0, n;
  pulse_source src (.clk(clk), .pins(pin_in));
  pulse_io_event_archiver #(.MS_CYCLES(10), .PER_DEPTH(12'h004)) dut (.clk(clk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_in(pin_in),
    .battery_ok(battery_ok), .overload(overload), .setpoint(setpoint), .error_bits(error_bits),
    .alarm_req(alarm_req), .volume_pulse(volume_pulse), .vol_stb(vol_stb), .err_cond(err_cond),
    .meas_val(meas_val), .meas_stb(meas_stb), .out_pin(out_pin), .supply_en(supply_en), .rec_stb(rec_stb),
    .rec_kind(rec_kind), .rec_index(rec_index), .rec_time(rt), .rec_bits(rec_bits));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
    `CHK(s, e, rdata & m)
  endtask
  task refuse(input logic [7:0] a, input logic [31:0] v);
    wr(a, v);
    rc(`A_STATUS, 32'h10, 32'h10, "refused");
  endtask
  task t_reset;
    rc(`A_PERIOD, '1, 32'hE10, "period");
    rc(8'h70, '1, 32'h0, "unmapped");
    rc(`A_STATUS, 32'hC, 32'hC, "supply on");
    overload <= 2'h1;
    repeat (6) @(posedge clk);
    rc(`A_STATUS, 32'hC, 32'h8, "supply cut");
    overload <= 2'h0;
  endtask
  task t_count;
    refuse(`A_METER, 32'h3);
    refuse(`A_METER, 32'h5);
    wr(`A_METER, 32'h6);
    rc(`A_METER, '1, 32'h6, "meter");
    refuse(`A_IN_MODE, 32'h3);
    wr(`A_IN_MODE, 32'h4);
    src.burst(0, 3);
    src.burst(1, 2);
    repeat (4) @(posedge clk);
    rc(8'h30, '1, 32'd3, "lf");
    rc(8'h34, '1, 32'd2, "hf");
    battery_ok <= 1'b0;
    repeat (4) @(posedge clk);
    src.burst(0, 2);
    rc(8'h40, '1, 32'd3, "backup off");
    battery_ok <= 1'b1;
    repeat (6) @(posedge clk);
    rc(8'h40, '1, 32'd5, "backup");
  endtask
  task t_misc;
    vol_stb <= 1'b1;
    repeat (2) @(posedge clk);
    err_cond <= 1'b1;
    @(posedge clk);
    vol_stb <= 1'b0;
    err_cond <= 1'b0;
    rc(`A_BASE_VOL, '1, 32'd2, "base");
    rc(`A_ERR_VOL, '1, 32'd1, "err");
    meas_val <= 16'h0064;
    wr(`A_CMD, 32'h1);
    rc(`A_MIN, '1, 32'h64, "min init");
    meas_stb <= 1'b1;
    meas_val <= 16'h0032;
    @(posedge clk);
    meas_val <= 16'h00C8;
    @(posedge clk);
    meas_stb <= 1'b0;
    rc(`A_MIN, '1, 32'h32, "min");
    rc(`A_MAX, '1, 32'hC8, "max");
  endtask
  task t_out;
    alarm_req <= 4'h8;
    wr(`A_OUT_CFG, 32'h31);
    wr(`A_OUT_TIME, 32'h0002_0001);
    wr(`A_OUT_CMD, 32'h0003_0016);
    n = 0;
    d = '0;
    repeat (200) begin
      @(posedge clk);
      n += (out_pin[0] && !d[0]);
      d[0] = out_pin[0];
    end
    `CHK("pulses", 3, n)
    `CHK("levels", 3'h5, out_pin[3:1])
  endtask
  task t_per;
    refuse(`A_PERIOD, 32'h0);
    refuse(`A_PERIOD, 32'hE11);
    wr(`A_PERIOD, 32'h1);
    wr(`A_DAYTIME, 32'h0100_545F);
    wr(`A_BIN_CFG, 32'h0000_00EF);
    for (int i = 0; i < 5; i++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (!(rec_stb === 1'b1 && rec_kind === 3'h0) && n < 12000);
      `CHK("periodic", 1'b1, rec_stb)
      if (i > 0) `CHK("slot", 15'((prv + 1) % 4), rec_index)
      if (i == 1) `CHK("sticky", 1'b1, rec_bits[8])
      if (i == 2) `CHK("cleared", 1'b0, rec_bits[8])
      if (i == 3) `CHK("level", 1'b1, rec_bits[4])
      if (i > 0) `CHK("stamp", d + 1, rt)
      d = rt;
      prv = rec_index;
      if (i == 0) begin
        setpoint <= 4'h1;
        @(posedge clk);
        setpoint <= 4'h0;
      end
    end
  endtask
  task give_verdict;
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 80000) begin
        n_errors++;
        give_verdict;
      end
    end
  end
  initial begin
    {reset_n, wr_stb, rd_stb, vol_stb, err_cond, meas_stb} = '0;
    {addr, wdata, meas_val, overload, setpoint, error_bits, alarm_req, volume_pulse} = '0;
    battery_ok = 1'b1;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_count;
    t_misc;
    t_out;
    t_per;
    give_verdict;
  end
endmodule
